// >>> testbench/amd_mem_model.sv
// amd_mem_model: byte-wide program and data memory answering the decoder's reads
// assumes: shares ref_clk with the decoder; the bench fills mem and sets lat
`timescale 1ns/1ps
`default_nettype none

module amd_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        mem_rd,
    input  wire logic [15:0] mem_addr,
    output logic      [7:0]  mem_rdata,
    output logic             mem_rvalid
);
    logic [7:0] mem [0:65535];
    int         lat;
    int         wait_cnt;

    initial begin
        lat        = 0;
        wait_cnt   = 0;
        mem_rvalid = 1'b0;
        mem_rdata  = 8'h00;
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'hA5;
        end
    end

    // data is inverted outside answer cycles so a stale byte never looks fresh
    always @(posedge ref_clk) begin
        #2;
        if (mem_rvalid || !rst_n) begin
            mem_rvalid = 1'b0;
            mem_rdata  = ~mem_rdata;
            wait_cnt   = 0;
        end else if (mem_rd && wait_cnt >= lat) begin
            mem_rvalid = 1'b1;
            mem_rdata  = mem[mem_addr];
        end else begin
            mem_rdata = ~mem_rdata;
            wait_cnt  = mem_rd ? wait_cnt + 1 : 0;
        end
    end
endmodule // amd_mem_model

`default_nettype wire

// >>> testbench/tb_top.sv
// tb_top: self-checking bench for the addressing-mode decoder
// assumes: amd_pkg and the decoder are compiled first; memory model beside it
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic                 ref_clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 start = 1'b0;
    amd_pkg::amd_mode_t   opcode_mode = amd_pkg::mode_inherent;
    amd_pkg::amd_cls_t    op_class = amd_pkg::cls_inherent_only;
    amd_pkg::amd_inh_op_t inh_op = amd_pkg::inh_nop;
    logic [7:0]           prebyte = 8'h00;
    logic [15:0]          program_counter_in = 16'h0000;
    logic [7:0]           index_x = 8'h00;
    logic [7:0]           index_y = 8'h00;
    logic [7:0]           mem_rdata;
    logic                 mem_rvalid, busy, mem_rd, done, mode_err, low_power_req, stack_reset_req;
    logic [15:0]          mem_addr, eff_addr, branch_target, next_program_counter;
    logic [2:0]           instr_len;
    int                   n_errors = 0;
    int                   checks = 0;

    always #12.5 ref_clk = ~ref_clk;

    amd_decoder dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .start(start),
        .opcode_mode(opcode_mode), .op_class(op_class), .inh_op(inh_op), .prebyte(prebyte),
        .program_counter_in(program_counter_in), .index_x(index_x), .index_y(index_y),
        .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .busy(busy), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .done(done), .mode_err(mode_err), .eff_addr(eff_addr),
        .branch_target(branch_target), .next_program_counter(next_program_counter),
        .instr_len(instr_len), .low_power_req(low_power_req),
        .stack_reset_req(stack_reset_req));

    amd_mem_model mem_u (.ref_clk(ref_clk), .rst_n(rst_n), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one instruction: nb operand bytes, disp is the signed branch offset
    task automatic xfer(input amd_pkg::amd_mode_t m, input amd_pkg::amd_cls_t c,
        input amd_pkg::amd_inh_op_t op, input logic [7:0] pre, input logic [15:0] pc,
        input logic [2:0] nb, input logic [15:0] eff, input logic [15:0] disp,
        input logic err);
        logic [15:0] npc;
        logic        inh;
        int          k;
        npc = pc + 16'h0001 + {13'h0000, nb};
        inh = (m == amd_pkg::mode_inherent);
        opcode_mode = m;
        op_class = c;
        inh_op = op;
        prebyte = pre;
        program_counter_in = pc;
        start = 1'b1;
        @(posedge ref_clk);
        #2 start = 1'b0;
        cmp(16'(busy), 16'h0001);
        k = 0;
        while (done !== 1'b1 && k < 60) begin
            @(posedge ref_clk);
            #2 k++;
        end
        if (k == 60) begin
            n_errors++;
            $display("ERROR t=%0t done never came", $time);
            tally_and_finish();
        end
        cmp(16'(mode_err), 16'(err));
        cmp(16'(busy), 16'h0000);
        if (!err) begin
            cmp(16'(instr_len), 16'(3'h1 + nb + 3'(pre inside {8'h90, 8'h91, 8'h92})));
            cmp(next_program_counter, npc);
            cmp(branch_target, npc + disp);
            cmp(16'(low_power_req), 16'(inh && op inside {amd_pkg::wait_for_interrupt_op,
                amd_pkg::inh_osc_halt}));
            cmp(16'(stack_reset_req), 16'(inh && op == amd_pkg::stack_pointer_reset_op));
            if (!inh && m != amd_pkg::mode_rel_direct) begin
                cmp(eff_addr, eff);
            end
        end
    endtask

    task automatic t_inherent();
        for (int i = 0; i < 12; i++) begin
            xfer(amd_pkg::mode_inherent, amd_pkg::cls_inherent_only, amd_pkg::amd_inh_op_t'(i),
                8'h00, 16'h0100, 3'h0, 16'h0000, 16'h0000, 1'b0);
        end
    endtask

    task automatic t_immediate();
        xfer(amd_pkg::mode_immediate, amd_pkg::cls_long_short, amd_pkg::inh_nop, 8'h00,
            16'h2000, 3'h1, 16'h2001, 16'h0000, 1'b0);
        xfer(amd_pkg::mode_immediate, amd_pkg::cls_short_only, amd_pkg::inh_nop, 8'h00,
            16'h2000, 3'h1, 16'h2001, 16'h0000, 1'b1);
    endtask

    task automatic t_direct();
        mem_u.mem[16'h3001] = 8'hC3;
        mem_u.mem[16'h3101] = 8'h12;
        mem_u.mem[16'h3102] = 8'h34;
        xfer(amd_pkg::mode_dir_short, amd_pkg::cls_short_only, amd_pkg::inh_nop, 8'h00,
            16'h3000, 3'h1, 16'h00C3, 16'h0000, 1'b0);
        xfer(amd_pkg::mode_dir_long, amd_pkg::cls_long_short, amd_pkg::inh_nop, 8'h00,
            16'h3100, 3'h2, 16'h1234, 16'h0000, 1'b0);
        xfer(amd_pkg::mode_dir_long, amd_pkg::cls_short_only, amd_pkg::inh_nop, 8'h00,
            16'h3100, 3'h2, 16'h1234, 16'h0000, 1'b1);
    endtask

    task automatic t_indexed();
        index_x = 8'hFF;
        index_y = 8'h7E;
        mem_u.mem[16'h4001] = 8'hFF;
        mem_u.mem[16'h4101] = 8'h12;
        mem_u.mem[16'h4102] = 8'h34;
        xfer(amd_pkg::mode_idx_none, amd_pkg::cls_short_only, amd_pkg::inh_nop, 8'h90,
            16'h4000, 3'h0, 16'h007E, 16'h0000, 1'b0);
        xfer(amd_pkg::mode_idx_short, amd_pkg::cls_short_only, amd_pkg::inh_nop, 8'h00,
            16'h4000, 3'h1, 16'h01FE, 16'h0000, 1'b0);
        xfer(amd_pkg::mode_idx_long, amd_pkg::cls_long_short, amd_pkg::inh_nop, 8'h00,
            16'h4100, 3'h2, 16'h1333, 16'h0000, 1'b0);
    endtask

    // slow memory here: each byte waits two extra cycles
    task automatic t_indirect();
        mem_u.lat = 2;
        index_x = 8'hFF;
        index_y = 8'h10;
        mem_u.mem[16'h5001] = 8'hFF;
        mem_u.mem[16'h00FF] = 8'hAB;
        mem_u.mem[16'h0100] = 8'hCD;
        xfer(amd_pkg::mode_ind_short, amd_pkg::cls_short_only, amd_pkg::inh_nop, 8'h00,
            16'h5000, 3'h1, 16'h00AB, 16'h0000, 1'b0);
        xfer(amd_pkg::mode_ind_long, amd_pkg::cls_long_short, amd_pkg::inh_nop, 8'h00,
            16'h5000, 3'h1, 16'hABCD, 16'h0000, 1'b0);
        xfer(amd_pkg::mode_dir_short, amd_pkg::cls_short_only, amd_pkg::inh_nop, 8'h92,
            16'h5000, 3'h1, 16'h00AB, 16'h0000, 1'b0);
        xfer(amd_pkg::mode_indidx_short, amd_pkg::cls_short_only, amd_pkg::inh_nop, 8'h00,
            16'h5000, 3'h1, 16'h01AA, 16'h0000, 1'b0);
        xfer(amd_pkg::mode_idx_short, amd_pkg::cls_short_only, amd_pkg::inh_nop, 8'h91,
            16'h5000, 3'h1, 16'h00BB, 16'h0000, 1'b0);
        xfer(amd_pkg::mode_indidx_long, amd_pkg::cls_long_short, amd_pkg::inh_nop, 8'h00,
            16'h5000, 3'h1, 16'hACCC, 16'h0000, 1'b0);
        mem_u.lat = 0;
    endtask

    task automatic t_relative();
        mem_u.mem[16'h6001] = 8'h80;
        mem_u.mem[16'h0080] = 8'h7F;
        xfer(amd_pkg::mode_rel_direct, amd_pkg::conditional_relative_branch, amd_pkg::inh_nop,
            8'h00, 16'h6000, 3'h1, 16'h0000, 16'hFF80, 1'b0);
        xfer(amd_pkg::mode_rel_direct, amd_pkg::relative_subroutine_call, amd_pkg::inh_nop,
            8'h92, 16'h6000, 3'h1, 16'h0000, 16'h007F, 1'b0);
        xfer(amd_pkg::mode_rel_direct, amd_pkg::cls_long_short, amd_pkg::inh_nop, 8'h00,
            16'h6000, 3'h1, 16'h0000, 16'h0000, 1'b1);
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        #2 rst_n = 1'b1;
        t_inherent();
        t_immediate();
        t_direct();
        t_indexed();
        t_indirect();
        t_relative();
        tally_and_finish();
    end
endmodule // tb_top

`default_nettype wire

// >>> verilog/amd_addr_add.sv
// amd_addr_add: 16-bit base plus an 8-bit offset, zero- or sign-extended
// assumes: purely combinational, used by the decoder for indexing and branches
`timescale 1ns/1ps
`default_nettype none

module amd_addr_add #(
    parameter bit SIGN_EXT = 1'b0
) (
    input  wire logic [15:0] base,
    input  wire logic [7:0]  ofs,
    output logic      [15:0] sum
);
    logic [15:0] ofs_ext;

    // full 16-bit add, so no wrap inside the low byte [RULE_22]
    assign ofs_ext = SIGN_EXT ? {{8{ofs[7]}}, ofs} : {8'h00, ofs};
    assign sum     = base + ofs_ext;
endmodule // amd_addr_add

`default_nettype wire

// >>> verilog/amd_decoder.sv
// amd_decoder: instruction length and effective-address sequencer
// assumes: opcode decoder gives mode and class; memory answers on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "amd_params.svh"

// Functional notes
// RULE_01: inherent instructions are one byte; no operand fetch.
// RULE_02: immediate is opcode plus literal; only load/compare/logic/arith classes.
// RULE_03: short direct fetches one address byte; range 00 to FF.
// RULE_04: long direct fetches a two-byte address word; full 64K.
// RULE_05: direct indexed address is unsigned index plus instruction offset.
// RULE_06: no-offset indexed has no operand byte; index alone is address.
// RULE_07: short indexed adds offset byte to index, carry kept, up to 1FE.
// RULE_08: long indexed adds a two-byte offset word to index; full 64K.
// RULE_09: indirect modes read the operand address from the pointer location.
// RULE_10: short indirect reads a one-byte pointer; range 00 to FF.
// RULE_11: long indirect reads a two-byte pointer word; full 64K.
// RULE_12: indirect indexed address is pointer value plus index register.
// RULE_13: short indirect indexed keeps the carry, giving up to 1FE.
// RULE_14: load/compare/logic/arith classes accept short and long forms.
// RULE_15: memory read-modify-write classes accept only short forms.
// RULE_16: relative modes add a signed 8-bit offset to the program counter.
// RULE_17: direct relative takes displacement right after the opcode.
// RULE_18: indirect relative reads the displacement from the addressed byte.
// RULE_19: single-byte group includes trap, wait, halt, returns, flags, stack reset.
// RULE_20: branch base is the address of the following instruction.
// RULE_21: prebytes select second index, indirect forms, or indirect second index.
// RULE_22: byte addresses zero-extend to 16 bits; index add never wraps low byte.
module amd_decoder (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic                 start,
    input  wire amd_pkg::amd_mode_t   opcode_mode,
    input  wire amd_pkg::amd_cls_t    op_class,
    input  wire amd_pkg::amd_inh_op_t inh_op,
    input  wire logic [7:0]           prebyte,
    input  wire logic [15:0]          program_counter_in,
    input  wire logic [7:0]           index_x,
    input  wire logic [7:0]           index_y,
    input  wire logic [7:0]           mem_rdata,
    input  wire logic                 mem_rvalid,
    output logic                      busy,
    output logic                      mem_rd,
    output logic [15:0]               mem_addr,
    output logic                      done,
    output logic                      mode_err,
    output logic [15:0]               eff_addr,
    output logic [15:0]               branch_target,
    output logic [15:0]               next_program_counter,
    output logic [2:0]                instr_len,
    output logic                      low_power_req,
    output logic                      stack_reset_req
);
    amd_pkg::amd_state_t  st;
    amd_pkg::amd_state_t  next_st;
    amd_pkg::amd_mode_t   mode_q;
    amd_pkg::amd_mode_t   eff_mode_in;
    amd_pkg::amd_inh_op_t inh_q;
    logic [15:0] pc_q;
    logic [7:0]  idx_q;
    logic [7:0]  b1, b2, p1, p2;
    logic        pre_q, err_q;

    // prebyte decode [RULE_21]
    logic pre_y, pre_ind, pre_indy, has_pre, use_y_in;
    assign pre_y    = (prebyte == `AMD_SECOND_INDEX_SELECTOR);
    assign pre_ind  = (prebyte == `AMD_INDIRECT_SELECTOR);
    assign pre_indy = (prebyte == `AMD_INDIRECT_SECOND_INDEX_SELECTOR);
    assign has_pre  = pre_y | pre_ind | pre_indy;
    assign use_y_in = pre_y | pre_indy; // [RULE_21]

    // direct forms become indirect under the indirect selector, short and long indexed forms under both indirect selectors [RULE_21]
    logic to_ind;
    assign to_ind = pre_ind | pre_indy;
    always_comb begin
        eff_mode_in = opcode_mode;
        if (pre_ind) begin
            unique case (opcode_mode)
                amd_pkg::mode_dir_short:  eff_mode_in = amd_pkg::mode_ind_short;
                amd_pkg::mode_dir_long:   eff_mode_in = amd_pkg::mode_ind_long;
                amd_pkg::mode_rel_direct: eff_mode_in = amd_pkg::mode_rel_indirect;
                default:                  eff_mode_in = opcode_mode;
            endcase
        end
        if (to_ind && opcode_mode == amd_pkg::mode_idx_short) begin
            eff_mode_in = amd_pkg::mode_indidx_short;
        end
        if (to_ind && opcode_mode == amd_pkg::mode_idx_long) begin
            eff_mode_in = amd_pkg::mode_indidx_long;
        end
    end

    // legality of a form for a class
    logic in_long, in_rel, in_inh, in_imm, in_short, legal_in, no_opnd_in;
    assign in_long  = (eff_mode_in == amd_pkg::mode_dir_long)
                    | (eff_mode_in == amd_pkg::mode_idx_long)
                    | (eff_mode_in == amd_pkg::mode_ind_long)
                    | (eff_mode_in == amd_pkg::mode_indidx_long);
    assign in_rel   = (eff_mode_in == amd_pkg::mode_rel_direct)
                    | (eff_mode_in == amd_pkg::mode_rel_indirect);
    assign in_inh   = (eff_mode_in == amd_pkg::mode_inherent);
    assign in_imm   = (eff_mode_in == amd_pkg::mode_immediate);
    assign in_short = !in_long && !in_rel && !in_inh && !in_imm;
    assign legal_in = in_inh
        | ((in_imm | in_long | in_short) && op_class == amd_pkg::cls_long_short) // [RULE_02] [RULE_14]
        | (in_short && op_class == amd_pkg::cls_short_only)                    // [RULE_15]
        | (in_rel && (op_class == amd_pkg::conditional_relative_branch
                   || op_class == amd_pkg::relative_subroutine_call));         // [RULE_16]
    assign no_opnd_in = in_inh | (eff_mode_in == amd_pkg::mode_idx_none); // [RULE_01] [RULE_06]

    // attributes of the latched form
    logic two_opnd_q, ptr_q, word_ptr_q, indexed_q, rel_q, imm_q, none_q;
    assign two_opnd_q = (mode_q == amd_pkg::mode_dir_long)
                      | (mode_q == amd_pkg::mode_idx_long);          // [RULE_04] [RULE_08]
    assign word_ptr_q = (mode_q == amd_pkg::mode_ind_long)
                      | (mode_q == amd_pkg::mode_indidx_long);       // [RULE_11] [RULE_12]
    assign ptr_q      = word_ptr_q
                      | (mode_q == amd_pkg::mode_ind_short)
                      | (mode_q == amd_pkg::mode_indidx_short)
                      | (mode_q == amd_pkg::mode_rel_indirect);      // [RULE_09] [RULE_18]
    assign indexed_q  = (mode_q == amd_pkg::mode_idx_none)
                      | (mode_q == amd_pkg::mode_idx_short)
                      | (mode_q == amd_pkg::mode_idx_long)
                      | (mode_q == amd_pkg::mode_indidx_short)
                      | (mode_q == amd_pkg::mode_indidx_long);       // [RULE_05] [RULE_12]
    assign rel_q      = (mode_q == amd_pkg::mode_rel_direct)
                      | (mode_q == amd_pkg::mode_rel_indirect);
    assign imm_q      = (mode_q == amd_pkg::mode_immediate);
    assign none_q     = (mode_q == amd_pkg::mode_inherent)
                      | (mode_q == amd_pkg::mode_idx_none);

    logic       accept, got;
    assign accept = start && (st == amd_pkg::st_idle);
    assign got    = mem_rd && mem_rvalid;

    always_comb begin
        next_st = st;
        unique case (st)
            amd_pkg::st_idle: begin
                if (accept) begin
                    next_st = (!legal_in || no_opnd_in) ? amd_pkg::st_done : amd_pkg::st_opnd1;
                end
            end
            amd_pkg::st_opnd1: begin
                if (got) begin
                    next_st = two_opnd_q ? amd_pkg::st_opnd2 :
                              ptr_q      ? amd_pkg::st_ptr1  : amd_pkg::st_done;
                end
            end
            amd_pkg::st_opnd2: if (got) next_st = amd_pkg::st_done;
            amd_pkg::st_ptr1: begin
                if (got) begin
                    next_st = word_ptr_q ? amd_pkg::st_ptr2 : amd_pkg::st_done; // [RULE_10]
                end
            end
            amd_pkg::st_ptr2: if (got) next_st = amd_pkg::st_done;
            amd_pkg::st_done: next_st = amd_pkg::st_idle;
        endcase
    end

    // address of the next byte to fetch
    logic [15:0] next_fetch_addr;
    logic        next_fetch;
    assign next_fetch = (next_st == amd_pkg::st_opnd1) | (next_st == amd_pkg::st_opnd2)
                      | (next_st == amd_pkg::st_ptr1)  | (next_st == amd_pkg::st_ptr2);
    assign next_fetch_addr =
        (next_st == st)                ? mem_addr :  // hold until answered
        (next_st == amd_pkg::st_opnd1) ? program_counter_in + 16'h0001 :  // [RULE_03] [RULE_17]
        (next_st == amd_pkg::st_opnd2) ? pc_q + 16'h0002 :                 // [RULE_04] [RULE_08]
        (next_st == amd_pkg::st_ptr1)  ? {8'h00, mem_rdata} :              // [RULE_09] [RULE_22]
        (next_st == amd_pkg::st_ptr2)  ? {8'h00, b1} + 16'h0001 :          // [RULE_11]
                                         mem_addr;

    // effective-address selection; byte values zero-extend [RULE_22]
    logic [15:0] base_w, ea_w, npc_w, tgt_w;
    logic [7:0]  idx_add, disp_w;
    logic [2:0]  opnd_w, len_w;
    assign base_w = imm_q      ? pc_q + 16'h0001 :  // [RULE_02]
                    none_q     ? 16'h0000 :         // [RULE_06]
                    two_opnd_q ? {b1, b2} :         // [RULE_04] [RULE_08]
                    word_ptr_q ? {p1, p2} :         // [RULE_11]
                    ptr_q      ? {8'h00, p1} :      // [RULE_10] [RULE_13]
                                 {8'h00, b1};       // [RULE_03] [RULE_07]
    assign idx_add = indexed_q ? idx_q : 8'h00;      // [RULE_05] [RULE_12]
    assign disp_w  = (mode_q == amd_pkg::mode_rel_indirect) ? p1 : b1; // [RULE_17] [RULE_18]
    assign opnd_w  = none_q ? `AMD_OPND_NONE : two_opnd_q ? `AMD_OPND_TWO : `AMD_OPND_ONE;
    assign len_w   = `AMD_OPC_BYTES + opnd_w + {2'b00, pre_q}; // [RULE_01]
    // branch base is the following instruction [RULE_20]
    assign npc_w   = pc_q + {13'h0000, `AMD_OPC_BYTES + opnd_w};

    amd_addr_add #(.SIGN_EXT(1'b0)) u_index_add (  // [RULE_07] [RULE_13]
        .base (base_w),
        .ofs  (idx_add),
        .sum  (ea_w)
    );

    amd_addr_add #(.SIGN_EXT(1'b1)) u_branch_add ( // [RULE_16]
        .base (npc_w),
        .ofs  (disp_w),
        .sum  (tgt_w)
    );
    logic lp_w, sr_w;
    assign lp_w = (mode_q == amd_pkg::mode_inherent) && !err_q
               && (inh_q == amd_pkg::wait_for_interrupt_op
                || inh_q == amd_pkg::inh_osc_halt);                         // [RULE_19]
    assign sr_w = (mode_q == amd_pkg::mode_inherent) && !err_q
               && (inh_q == amd_pkg::stack_pointer_reset_op);               // [RULE_19]

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= amd_pkg::st_idle;
        end else begin
            st <= next_st;
        end
    end

    // instruction context is caught at start and held to the next start
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= amd_pkg::mode_inherent;
            inh_q  <= amd_pkg::inh_nop;
            pc_q   <= `AMD_RST_ADDR;
            idx_q  <= `AMD_RST_BYTE;
            pre_q  <= 1'b0;
            err_q  <= 1'b0;
        end else if (accept) begin
            mode_q <= eff_mode_in;
            inh_q  <= inh_op;
            pc_q   <= program_counter_in;
            idx_q  <= use_y_in ? index_y : index_x; // [RULE_21]
            pre_q  <= has_pre;
            err_q  <= !legal_in;                    // [RULE_15]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            b1 <= `AMD_RST_BYTE;
            b2 <= `AMD_RST_BYTE;
            p1 <= `AMD_RST_BYTE;
            p2 <= `AMD_RST_BYTE;
        end else if (got) begin
            // multi-byte words arrive high byte first
            if (st == amd_pkg::st_opnd1) b1 <= mem_rdata;
            if (st == amd_pkg::st_opnd2) b2 <= mem_rdata;
            if (st == amd_pkg::st_ptr1)  p1 <= mem_rdata;
            if (st == amd_pkg::st_ptr2)  p2 <= mem_rdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy     <= 1'b0;
            mem_rd   <= 1'b0;
            mem_addr <= `AMD_RST_ADDR;
        end else begin
            busy     <= (next_st != amd_pkg::st_idle);
            mem_rd   <= next_fetch;
            mem_addr <= next_fetch_addr;
        end
    end
    logic fin;
    assign fin = (st == amd_pkg::st_done);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            done                 <= 1'b0;
            mode_err             <= 1'b0;
            eff_addr             <= `AMD_RST_ADDR;
            branch_target        <= `AMD_RST_ADDR;
            next_program_counter <= `AMD_RST_ADDR;
            instr_len            <= `AMD_RST_LEN;
            low_power_req        <= 1'b0;
            stack_reset_req      <= 1'b0;
        end else begin
            done            <= fin;
            mode_err        <= fin && err_q;
            low_power_req   <= fin && lp_w;
            stack_reset_req <= fin && sr_w;
            if (fin) begin
                eff_addr             <= ea_w;
                branch_target        <= rel_q ? tgt_w : npc_w;
                next_program_counter <= npc_w;
                instr_len            <= len_w;
            end
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    inherent_len_a: assert property ( // [RULE_01]
        (done && !mode_err && mode_q == amd_pkg::mode_inherent && !pre_q) |->
            (instr_len == 3'h1 && next_program_counter == pc_q + 16'h0001))
        else $error("inherent length not one byte");
    imm_len_a: assert property ( // [RULE_02]
        (done && !mode_err && imm_q && !pre_q) |->
            (instr_len == 3'h2 && eff_addr == pc_q + 16'h0001))
        else $error("immediate length or operand address wrong");
    short_dir_range_a: assert property ( // [RULE_03]
        (done && !mode_err && mode_q == amd_pkg::mode_dir_short) |->
            (eff_addr == {8'h00, b1}))
        else $error("short direct address out of page zero");
    long_dir_fetch_a: assert property ( // [RULE_04]
        (st == amd_pkg::st_opnd1 && got && two_opnd_q) |=>
            (mem_rd && mem_addr == pc_q + 16'h0002) ##[0:200] got)
        else $error("second address byte not fetched");
    no_offset_a: assert property ( // [RULE_06]
        (done && !mode_err && mode_q == amd_pkg::mode_idx_none) |->
            (eff_addr == {8'h00, idx_q} && instr_len == 3'h1 + {2'b00, pre_q}))
        else $error("no-offset indexed address wrong");
    short_idx_sum_a: assert property ( // [RULE_07]
        (done && !mode_err && mode_q == amd_pkg::mode_idx_short) |->
            (eff_addr == {8'h00, b1} + {8'h00, idx_q}))
        else $error("short indexed sum lost carry");
    pointer_read_a: assert property ( // [RULE_09]
        (st == amd_pkg::st_opnd1 && got && ptr_q) |=>
            (mem_rd && mem_addr == {8'h00, $past(mem_rdata)}))
        else $error("pointer not read from its location");
    short_only_a: assert property ( // [RULE_15]
        (accept && op_class == amd_pkg::cls_short_only && in_long) |=>
            (!mem_rd ##1 (done && mode_err)))
        else $error("long form accepted for short-only class");
    rel_target_a: assert property ( // [RULE_16]
        (done && !mode_err && rel_q) |->
            (branch_target == next_program_counter + {{8{disp_w[7]}}, disp_w}))
        else $error("relative target wrong");
    fetch_hold_a: assert property (
        (mem_rd && !mem_rvalid) |=> (mem_rd && $stable(mem_addr)))
        else $error("fetch request dropped before answer");

    ind_long_c: cover property (done && !mode_err && mode_q == amd_pkg::mode_ind_long);
    rel_ind_c: cover property (done && !mode_err && mode_q == amd_pkg::mode_rel_indirect);
    idx_carry_c: cover property (done && mode_q == amd_pkg::mode_indidx_short
                                 && eff_addr[8]);
    err_c: cover property (done && mode_err);
endmodule // amd_decoder

`default_nettype wire

// >>> verilog/amd_params.svh
// amd_params.svh: constants of the addressing-mode decoder
// assumes: included by bare name from design files of this block
`ifndef AMD_PARAMS_SVH
`define AMD_PARAMS_SVH

// prebyte codes that modify the following opcode
`define AMD_SECOND_INDEX_SELECTOR          8'h90
`define AMD_INDIRECT_SELECTOR              8'h92
`define AMD_INDIRECT_SECOND_INDEX_SELECTOR 8'h91

// operand byte counts after the opcode, and the opcode byte count
`define AMD_OPND_NONE 3'h0
`define AMD_OPND_ONE  3'h1
`define AMD_OPND_TWO  3'h2
`define AMD_OPC_BYTES 3'h1

// reset values
`define AMD_RST_ADDR  16'h0000
`define AMD_RST_BYTE  8'h00
`define AMD_RST_LEN   3'h0

`endif

// >>> verilog/amd_pkg.sv
// amd_pkg: types of the addressing-mode decoder
// assumes: compiled before every design file of this block
`default_nettype none

package amd_pkg;

    // base addressing forms as the opcode decoder reports them
    typedef enum logic [3:0] {
        mode_inherent     = 4'h0,
        mode_immediate    = 4'h1,
        mode_dir_short    = 4'h2,
        mode_dir_long     = 4'h3,
        mode_idx_none     = 4'h4,
        mode_idx_short    = 4'h5,
        mode_idx_long     = 4'h6,
        mode_ind_short    = 4'h7,
        mode_ind_long     = 4'h8,
        mode_indidx_short = 4'h9,
        mode_indidx_long  = 4'hA,
        mode_rel_direct   = 4'hB,
        mode_rel_indirect = 4'hC
    } amd_mode_t;

    // instruction classes, by which forms they may use
    typedef enum logic [2:0] {
        cls_inherent_only           = 3'h0,
        cls_long_short              = 3'h1,
        cls_short_only              = 3'h2,
        conditional_relative_branch = 3'h3,
        relative_subroutine_call    = 3'h4
    } amd_cls_t;

    // single-byte operations
    typedef enum logic [3:0] {
        inh_nop               = 4'h0,
        inh_soft_interrupt    = 4'h1,
        wait_for_interrupt_op = 4'h2,
        inh_osc_halt          = 4'h3,
        inh_sub_return        = 4'h4,
        inh_int_return        = 4'h5,
        inh_set_int_mask      = 4'h6,
        inh_clr_int_mask      = 4'h7,
        inh_set_carry         = 4'h8,
        inh_clr_carry         = 4'h9,
        stack_pointer_reset_op = 4'hA,
        inh_register_op       = 4'hB
    } amd_inh_op_t;

    typedef enum logic [5:0] {
        st_idle  = 6'h01,
        st_opnd1 = 6'h02,
        st_opnd2 = 6'h04,
        st_ptr1  = 6'h08,
        st_ptr2  = 6'h10,
        st_done  = 6'h20
    } amd_state_t;

endpackage

`default_nettype wire
